// [hdl/tmr_params.svh]
// constants of the 8-bit timer/counter: offsets, field positions, resets
// assumes an AXI4-Lite slave with 8 address bits and 32-bit data
//
// Contract
// - count and both compare values 8 bits
// - flags visible, each masked individually
// - tick from prescaler or pin; zero stops
// - each tick clears, increments or decrements
// - cpu counter access always; write wins
// - three mode bits; overflow per mode
// - equal compare sets flag next tick
// - flag cleared by service or write-one
// - pwm modes double buffer at top/bottom
// - cpu reaches buffer when buffering, else active
// - force strobe acts like match outside pwm modes, no flag
// - counter write blocks match next tick
// - output state kept across mode change
// - output mode bits act immediately
// - output registers reset to zero
// - nonzero output mode overrides port value
// - output mode zero leaves output alone
// - top and bottom indications drive waveforms
// - bottom is 0x00, maximum is 0xff
// - top is maximum or compare value a
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH
// register byte offsets
`define TMR_OFS_CTRLA 8'h00
`define TMR_OFS_CTRLB 8'h04
`define TMR_OFS_COUNT 8'h08
`define TMR_OFS_CMPA 8'h0c
`define TMR_OFS_CMPB 8'h10
`define TMR_OFS_MASK 8'h14
`define TMR_OFS_FLAG 8'h18
// control register a fields (two bits each above, mode low bits at 1:0)
`define TMR_CA_COMA 6
`define TMR_CA_COMB 4
`define TMR_CA_WGM 0
// control register b fields
`define TMR_CB_FOCA 7
`define TMR_CB_FOCB 6
`define TMR_CB_WGM2 3
`define TMR_CB_CS 0
// flag and mask bit positions
`define TMR_FL_OVF 0
`define TMR_FL_CMPA 1
`define TMR_FL_CMPB 2
// values
`define TMR_RST_BYTE 8'h00
`define TMR_MAX 8'hff
`define TMR_BOTTOM 8'h00
`define TMR_RESP_OKAY 2'b00
`define TMR_RESP_SLVERR 2'b10
`endif

// [hdl/tmr_pkg.sv]
// types of the 8-bit timer/counter
// assumes tmr_params.svh holds all numeric constants
package tmr_pkg;
    // waveform generation modes, three bits
    typedef enum logic [2:0] {
        WGM_NORMAL = 3'b000,
        WGM_PC_MAX = 3'b001,
        WGM_CTC = 3'b010,
        WGM_FAST_MAX = 3'b011,
        WGM_RSV4 = 3'b100,
        WGM_PC_A = 3'b101,
        WGM_RSV6 = 3'b110,
        WGM_FAST_A = 3'b111
    } tmr_wgm_e;
    // one timer byte
    typedef logic [7:0] tmr_byte_t;
endpackage

// [hdl/tmr_cmp_if.sv]
// carrier between the counter core and one compare unit
// assumes one instance per compare channel, all on core_clk
`timescale 1ns/1ps
interface tmr_cmp_if;
    import tmr_pkg::*;
    logic tick; // timer tick this cycle
    logic noBlock; // matches allowed this tick
    tmr_byte_t count; // counter value
    logic pwm; // any pwm mode
    logic phase; // phase correct pwm
    logic countUp; // current direction
    logic bottomEv; // fast pwm wrap tick
    logic bufLoad; // move buffer into active
    logic wideToggle; // toggle allowed in pwm
    logic [1:0] com; // compare output mode
    logic wr; // cpu writes compare value
    tmr_byte_t wdata; // cpu write byte
    logic strobe; // force strobe
    tmr_byte_t active; // active compare value
    tmr_byte_t readback; // value cpu reads
    logic ocState; // output compare register
    logic matchEv; // accepted match pulse
    modport unit(input tick, noBlock, count, pwm, phase, countUp, bottomEv, bufLoad,
        wideToggle, com, wr, wdata, strobe, output active, readback, ocState, matchEv);
    modport ctl(output tick, noBlock, count, pwm, phase, countUp, bottomEv, bufLoad,
        wideToggle, com, wr, wdata, strobe, input active, readback, ocState, matchEv);
endinterface

// [hdl/tmr_cmp_unit.sv]
// one output compare unit: compare value, buffer and output register
// assumes the counter core drives tick, mode and cpu strobes on core_clk
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_cmp_unit (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // link to counter core
    tmr_cmp_if.unit cu
);
    import tmr_pkg::*;
    tmr_byte_t act_ff; // active compare value
    tmr_byte_t buf_ff; // double buffer
    logic oc_ff; // output compare register
    logic nxt_oc;
    wire logic isEqual = (cu.count == act_ff);
    wire logic hit = cu.tick & cu.noBlock & isEqual;
    wire logic forced = cu.strobe & ~cu.pwm;

    ////////////////////////////////////////////////////////////////////////////
    // output action; mode bits read live, never buffered
    always_comb begin
        nxt_oc = oc_ff;
        if (cu.com != 2'b00) begin
            if (!cu.pwm) begin
                if (hit | forced) begin
                    case (cu.com)
                        2'b01: nxt_oc = ~oc_ff;
                        2'b10: nxt_oc = 1'b0;
                        default: nxt_oc = 1'b1;
                    endcase
                end
            end else if (cu.phase) begin
                // mode 10 clears on up-count match and sets on down-count match, 11 the reverse
                if (hit) begin
                    if (cu.com == 2'b01) begin
                        nxt_oc = cu.wideToggle ? ~oc_ff : oc_ff;
                    end else begin
                        nxt_oc = (cu.com == 2'b10) ? ~cu.countUp : cu.countUp;
                    end
                end
            end else begin
                // bottom wins so a compare at max gives a steady level
                if (cu.bottomEv && cu.com[1]) begin
                    nxt_oc = ~cu.com[0];
                end else if (hit) begin
                    if (cu.com == 2'b01) begin
                        nxt_oc = cu.wideToggle ? ~oc_ff : oc_ff;
                    end else begin
                        nxt_oc = cu.com[0];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare value, buffer and output register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            act_ff <= `TMR_RST_BYTE;
            buf_ff <= `TMR_RST_BYTE;
            oc_ff <= 1'b0;
        end else begin
            oc_ff <= nxt_oc;
            if (cu.wr) begin
                buf_ff <= cu.wdata;
                if (!cu.pwm) begin
                    act_ff <= cu.wdata;
                end
            end else if (cu.bufLoad) begin
                act_ff <= buf_ff;
            end
        end
    end

    assign cu.active = act_ff;
    assign cu.readback = cu.pwm ? buf_ff : act_ff;
    assign cu.ocState = oc_ff;
    assign cu.matchEv = hit;
endmodule

// [hdl/tmr_counter_top.sv]
// 8-bit timer/counter with two compare units behind an AXI4-Lite slave
// assumes prescaler pulses on core_clk and port data/direction from the
// general port logic; the external count pin is asynchronous
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_counter_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // tick sources
    input wire logic [3:0] prescTick,
    input wire logic externalCountPin,
    // port logic and pins, index 0 is channel a
    input wire logic [1:0] portData,
    input wire logic [1:0] portDir,
    output logic [1:0] compareOutPin,
    output logic [1:0] compareOutOe_n,
    // interrupt requests and service acknowledge, bit order ovf, a, b
    input wire logic [2:0] irqAck,
    output logic [2:0] irqReq
);
    import tmr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    tmr_cmp_if cmpA(); // channel a link
    tmr_cmp_if cmpB(); // channel b link
    logic [1:0] comA_ff; // output mode a
    logic [1:0] comB_ff; // output mode b
    tmr_wgm_e wgm_ff; // waveform mode
    logic [2:0] clockSelect_ff; // tick source
    tmr_byte_t count_ff;
    logic countUp_ff; // phase correct direction
    logic block_ff; // match blocked after write
    logic [2:0] mask_ff; // timer mask register
    logic [2:0] flag_ff; // timer flag register
    logic [2:0] nxt_flag;
    tmr_byte_t nxt_count;
    logic nxt_up;
    logic ovfCond; // overflow condition on tick
    logic loadCond; // buffer load condition on tick
    logic wrapCond; // fast pwm wrap on tick
    // external pin synchroniser and edge detect
    logic extS1_ff, extS2_ff, extS3_ff;
    logic extLvl_ff, extPrev_ff;
    // axi state
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [7:0] awAddr_ff;
    logic [7:0] wByte_ff;
    logic wLane_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [31:0] rdMux;
    logic rdHit;
    // pin and request outputs
    logic [1:0] pinOut_ff, pinOeN_ff;
    logic [2:0] irq_ff;

    ////////////////////////////////////////////////////////////////////////////
    // mode decode
    wire logic isPwm = wgm_ff[0];
    wire logic isPhase = (wgm_ff == WGM_PC_MAX) || (wgm_ff == WGM_PC_A);
    wire logic isFast = (wgm_ff == WGM_FAST_MAX) || (wgm_ff == WGM_FAST_A);
    wire logic isCtc = (wgm_ff == WGM_CTC);
    wire logic topIsA = isCtc || (wgm_ff == WGM_PC_A) || (wgm_ff == WGM_FAST_A);
    wire tmr_byte_t topVal = topIsA ? cmpA.active : `TMR_MAX;
    wire logic atTop = (count_ff == topVal);
    wire logic atBottom = (count_ff == `TMR_BOTTOM);
    wire logic atMax = (count_ff == `TMR_MAX);

    ////////////////////////////////////////////////////////////////////////////
    // external pin: three flops, a change counts once stages two and three agree
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            extS1_ff <= 1'b0;
            extS2_ff <= 1'b0;
            extS3_ff <= 1'b0;
            extLvl_ff <= 1'b0;
            extPrev_ff <= 1'b0;
        end else begin
            extS1_ff <= externalCountPin;
            extS2_ff <= extS1_ff;
            extS3_ff <= extS2_ff;
            if (extS2_ff == extS3_ff) begin
                extLvl_ff <= extS3_ff;
            end
            extPrev_ff <= extLvl_ff;
        end
    end
    wire logic extRise = extLvl_ff & ~extPrev_ff;
    wire logic extFall = ~extLvl_ff & extPrev_ff;

    ////////////////////////////////////////////////////////////////////////////
    // tick select: 0 stop, 1 core clock, 2-5 prescaler taps, 6 fall, 7 rise
    wire logic [1:0] tapSel = 2'(clockSelect_ff - 3'd2);
    wire logic timerTick = (clockSelect_ff == 3'd0) ? 1'b0 :
        (clockSelect_ff == 3'd1) ? 1'b1 :
        (clockSelect_ff == 3'd6) ? extFall :
        (clockSelect_ff == 3'd7) ? extRise :
        prescTick[tapSel];

    ////////////////////////////////////////////////////////////////////////////
    // counting sequence per mode
    always_comb begin
        nxt_count = 8'(count_ff + 8'h01);
        nxt_up = countUp_ff;
        ovfCond = 1'b0;
        loadCond = 1'b0;
        wrapCond = 1'b0;
        if (isPhase) begin
            // dual slope: turn at top, turn again at bottom
            if (countUp_ff) begin
                if (atTop) begin
                    nxt_count = 8'(count_ff - 8'h01);
                    nxt_up = 1'b0;
                    loadCond = 1'b1;
                end
            end else begin
                if (atBottom) begin
                    nxt_up = 1'b1;
                    ovfCond = 1'b1;
                end else begin
                    nxt_count = 8'(count_ff - 8'h01);
                end
            end
        end else if (isFast) begin
            // single slope: wrap top to bottom, buffer moves on the wrap
            nxt_up = 1'b1;
            if (atTop) begin
                nxt_count = `TMR_BOTTOM;
                ovfCond = 1'b1;
                loadCond = 1'b1;
                wrapCond = 1'b1;
            end
        end else begin
            // normal, ctc and reserved codes count up
            nxt_up = 1'b1;
            ovfCond = atMax;
            if (isCtc && atTop) begin
                nxt_count = `TMR_BOTTOM;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi write decode, one byte lane carries each register
    wire logic wrFire = ~awready_ff & ~wready_ff & ~bvalid_ff;
    wire logic selCtrlA = (awAddr_ff == `TMR_OFS_CTRLA);
    wire logic selCtrlB = (awAddr_ff == `TMR_OFS_CTRLB);
    wire logic selCount = (awAddr_ff == `TMR_OFS_COUNT);
    wire logic selCmpA = (awAddr_ff == `TMR_OFS_CMPA);
    wire logic selCmpB = (awAddr_ff == `TMR_OFS_CMPB);
    wire logic selMask = (awAddr_ff == `TMR_OFS_MASK);
    wire logic selFlag = (awAddr_ff == `TMR_OFS_FLAG);
    wire logic wrHit = selCtrlA | selCtrlB | selCount | selCmpA | selCmpB | selMask | selFlag;
    wire logic wrEn = wrFire & wLane_ff;
    wire logic wrCount = wrEn & selCount;
    wire logic wrFlag = wrEn & selFlag;

    ////////////////////////////////////////////////////////////////////////////
    // write address and data channels, taken in either order
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= `TMR_RESP_OKAY;
            awAddr_ff <= 8'h00;
            wByte_ff <= 8'h00;
            wLane_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid && awready_ff) begin
                awAddr_ff <= s_axi_awaddr;
                awready_ff <= 1'b0;
            end else if (bvalid_ff && s_axi_bready) begin
                awready_ff <= 1'b1;
            end
            if (s_axi_wvalid && wready_ff) begin
                wByte_ff <= s_axi_wdata[7:0];
                wLane_ff <= s_axi_wstrb[0];
                wready_ff <= 1'b0;
            end else if (bvalid_ff && s_axi_bready) begin
                wready_ff <= 1'b1;
            end
            // response once both halves are held
            if (wrFire) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wrHit ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control, mask and counter registers; a cpu write beats the tick
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            comA_ff <= 2'b00;
            comB_ff <= 2'b00;
            wgm_ff <= WGM_NORMAL;
            clockSelect_ff <= 3'b000;
            mask_ff <= 3'b000;
            count_ff <= `TMR_RST_BYTE;
            countUp_ff <= 1'b1;
            block_ff <= 1'b0;
        end else begin
            if (wrEn && selCtrlA) begin
                comA_ff <= wByte_ff[`TMR_CA_COMA +: 2];
                comB_ff <= wByte_ff[`TMR_CA_COMB +: 2];
                wgm_ff <= tmr_wgm_e'({wgm_ff[2], wByte_ff[`TMR_CA_WGM +: 2]});
            end
            if (wrEn && selCtrlB) begin
                wgm_ff <= tmr_wgm_e'({wByte_ff[`TMR_CB_WGM2], wgm_ff[1:0]});
                clockSelect_ff <= wByte_ff[`TMR_CB_CS +: 3];
            end
            if (wrEn && selMask) begin
                mask_ff <= wByte_ff[2:0];
            end
            if (wrCount) begin
                count_ff <= wByte_ff;
                block_ff <= 1'b1;
            end else if (timerTick) begin
                count_ff <= nxt_count;
                countUp_ff <= nxt_up;
                block_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags: hardware set wins over service and write-one clear
    wire logic ovfEv = timerTick & ovfCond & ~wrCount;
    wire logic [2:0] flagSet = {cmpB.matchEv, cmpA.matchEv, ovfEv};
    wire logic [2:0] flagClr = irqAck | (wrFlag ? wByte_ff[2:0] : 3'b000);
    assign nxt_flag = (flag_ff & ~flagClr) | flagSet;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flag_ff <= 3'b000;
            irq_ff <= 3'b000;
        end else begin
            flag_ff <= nxt_flag;
            irq_ff <= flag_ff & mask_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare unit links
    wire logic tickLink = timerTick & ~wrCount;
    assign cmpA.tick = tickLink;
    assign cmpA.noBlock = ~block_ff;
    assign cmpA.count = count_ff;
    assign cmpA.pwm = isPwm;
    assign cmpA.phase = isPhase;
    assign cmpA.countUp = countUp_ff;
    assign cmpA.bottomEv = tickLink & wrapCond;
    assign cmpA.bufLoad = tickLink & loadCond & isPwm;
    assign cmpA.wideToggle = wgm_ff[2];
    assign cmpA.com = comA_ff;
    assign cmpA.wr = wrEn & selCmpA;
    assign cmpA.wdata = wByte_ff;
    assign cmpA.strobe = wrEn & selCtrlB & wByte_ff[`TMR_CB_FOCA];
    assign cmpB.tick = tickLink;
    assign cmpB.noBlock = ~block_ff;
    assign cmpB.count = count_ff;
    assign cmpB.pwm = isPwm;
    assign cmpB.phase = isPhase;
    assign cmpB.countUp = countUp_ff;
    assign cmpB.bottomEv = tickLink & wrapCond;
    assign cmpB.bufLoad = tickLink & loadCond & isPwm;
    assign cmpB.wideToggle = 1'b0; // toggle in pwm is a channel a option only
    assign cmpB.com = comB_ff;
    assign cmpB.wr = wrEn & selCmpB;
    assign cmpB.wdata = wByte_ff;
    assign cmpB.strobe = wrEn & selCtrlB & wByte_ff[`TMR_CB_FOCB];

    // compare unit a
    tmr_cmp_unit unitA (
        .core_clk(core_clk),
        .rst(rst),
        .cu(cmpA)
    );
    // compare unit b
    tmr_cmp_unit unitB (
        .core_clk(core_clk),
        .rst(rst),
        .cu(cmpB)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read mux; force strobes always read back as zero
    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        if (s_axi_araddr == `TMR_OFS_CTRLA) begin
            rdMux[7:0] = {comA_ff, comB_ff, 2'b00, wgm_ff[1:0]};
        end else if (s_axi_araddr == `TMR_OFS_CTRLB) begin
            rdMux[7:0] = {4'h0, wgm_ff[2], clockSelect_ff};
        end else if (s_axi_araddr == `TMR_OFS_COUNT) begin
            rdMux[7:0] = count_ff;
        end else if (s_axi_araddr == `TMR_OFS_CMPA) begin
            rdMux[7:0] = cmpA.readback;
        end else if (s_axi_araddr == `TMR_OFS_CMPB) begin
            rdMux[7:0] = cmpB.readback;
        end else if (s_axi_araddr == `TMR_OFS_MASK) begin
            rdMux[2:0] = mask_ff;
        end else if (s_axi_araddr == `TMR_OFS_FLAG) begin
            rdMux[2:0] = flag_ff;
        end else begin
            rdHit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel: data sampled at the address handshake
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `TMR_RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rdMux;
            rresp_ff <= rdHit ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin override; direction stays with the port logic
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pinOut_ff <= 2'b00;
            pinOeN_ff <= 2'b11;
        end else begin
            pinOut_ff[0] <= (comA_ff != 2'b00) ? cmpA.ocState : portData[0];
            pinOut_ff[1] <= (comB_ff != 2'b00) ? cmpB.ocState : portData[1];
            pinOeN_ff <= ~portDir;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign compareOutPin = pinOut_ff;
    assign compareOutOe_n = pinOeN_ff;
    assign irqReq = irq_ff;
endmodule

// [tb/tmr_counter_top_assertions.sv]
// checker of the timer's bus handshakes and pin direction
// assumes it is bound into tmr_counter_top and sees only its ports
`timescale 1ns/1ps
module tmr_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic [1:0] portDir,
    input wire logic [1:0] compareOutOe_n
);
    // one clock domain, so clock and reset are given once
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_oe_dir: assert property (!$past(rst) |-> compareOutOe_n == ~$past(portDir)) else $error("oe not from dir");
    a_b_timing: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
        ##1 !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
    a_w_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
    a_w_back: assert property ($fell(s_axi_bvalid) |-> s_axi_awready && s_axi_wready) else $error("no reopen");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("rvalid stuck");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
endmodule

// [tb/tmr_tick_model.sv]
// prescaler taps and external count pin feeding the timer
// assumes core_clk only; taps pulse one cycle at fixed divisions
`timescale 1ns/1ps
module tmr_tick_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // tick sources
    output logic [3:0] prescTick,
    output logic externalCountPin
);
    logic [9:0] divCnt; // free running divider, restarts at reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) divCnt <= 10'h000;
        else divCnt <= divCnt + 10'h001;
    end
    // taps every 8, 64, 256, 1024 clocks; slow pin so the sync sees each level
    assign prescTick = {divCnt == 10'h3ff, divCnt[7:0] == 8'hff, divCnt[5:0] == 6'h3f, divCnt[2:0] == 3'h7};
    assign externalCountPin = divCnt[3];
endmodule

// [tb/tb_timer8_counter_compare_unit.sv]
// bench of the 8-bit timer: bus access, ticks, flags, force and pin override
// assumes the tick model feeds the prescaler taps and the count pin
`timescale 1ns/1ps
`include "tmr_params.svh"
module tb_timer8_counter_compare_unit;
    logic core_clk = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, externalCountPin;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, x;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hf, prescTick;
    logic [1:0] portData = 2'b00, portDir = 2'b00, s_axi_bresp, s_axi_rresp, compareOutPin, compareOutOe_n;
    logic [2:0] irqAck = 3'b000, irqReq;
    int num_errors = 0, n_compared = 0, seed = 34, i;
    int unsigned mdl[7] = '{default: 0}; // register mirror
    int unsigned msk[7] = '{8'hf3, 8'h0f, 8'hff, 8'hff, 8'hff, 8'h07, 8'h07}; // readable bits
    always #12.5 core_clk = ~core_clk;
    tmr_counter_top uut (.*);
    tmr_tick_model ticks (.*);
    task automatic give_verdict;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        num_errors += (seen !== exp);
        if (seen !== exp) $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    endtask
    // one transfer; each channel released at its handshake
    task automatic bus(input logic wrt, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge core_clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wrt}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wrt}};
        repeat (50) begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if ((wrt ? s_axi_bvalid : s_axi_rvalid) === 1'b1) break;
        end
        {s_axi_bready, s_axi_rready} <= 2'b00;
        rv = s_axi_rdata;
        chk("answer", {31'h0, wrt ? s_axi_bvalid : s_axi_rvalid}, 32'h1);
        if ((wrt ? s_axi_bvalid : s_axi_rvalid) !== 1'b1) give_verdict;
        chk("resp", {30'h0, wrt ? s_axi_bresp : s_axi_rresp}, {30'h0, er});
    endtask
    task automatic put(input int r, input logic [7:0] d);
        bus(1'b1, 8'(r * 4), {24'h0, d}, `TMR_RESP_OKAY);
        mdl[r] = d & msk[r];
    endtask
    task automatic get(input int r);
        bus(1'b0, 8'(r * 4), 32'h0, `TMR_RESP_OKAY);
        chk("reg", rv, mdl[r]);
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        for (i = 0; i < 7; i++) get(i);
        bus(1'b1, 8'h1c, 32'h0, `TMR_RESP_SLVERR);
        bus(1'b0, 8'h02, 32'h0, `TMR_RESP_SLVERR);
        for (i = 2; i < 6; i++) put(i, 8'($random(seed)));
        repeat (20) @(posedge core_clk);
        for (i = 2; i < 6; i++) get(i);
        // pass 0 on compare a (blocked), pass 1 three below
        x = (8'($random(seed)) & 8'h3f) | 8'h08;
        put(3, x);
        put(4, x ^ 8'h80);
        put(5, 8'h02);
        for (i = 0; i < 2; i++) begin
            put(2, x - 8'(3 * i));
            put(1, 8'h01);
            put(1, 8'h00);
            mdl[6] = 2 * i;
            get(6);
        end
        chk("irq", {29'h0, irqReq}, 32'h2);
        irqAck <= 3'b010;
        @(posedge core_clk);
        irqAck <= 3'b000;
        mdl[6] = 0;
        get(6);
        put(2, 8'hfe);
        put(1, 8'h01);
        put(1, 8'h00);
        mdl[6] = 1;
        get(6);
        bus(1'b1, 8'h18, 32'h7, `TMR_RESP_OKAY);
        mdl[6] = 0;
        get(6);
        // force a toggle, then change mode while stopped
        portData <= 2'($random(seed));
        put(0, 8'h40);
        repeat (2) @(posedge core_clk);
        chk("oc", {31'h0, compareOutPin[0]}, 32'h0);
        put(1, 8'h80);
        portDir <= 2'b01;
        put(0, 8'h43);
        chk("pin", {30'h0, compareOutPin}, {30'h0, portData[1], 1'b1});
        chk("oe", {30'h0, compareOutOe_n}, 32'h2);
        get(6);
        put(3, ~x);
        get(3);
        put(0, 8'h00);
        mdl[3] = x;
        get(3);
        for (i = 1; i < 8; i++) begin
            put(2, 8'h00);
            put(1, 8'(i));
            repeat (1100) @(posedge core_clk);
            put(1, 8'h00);
            bus(1'b0, 8'h08, 32'h0, `TMR_RESP_OKAY);
            chk("ticked", {31'h0, rv != 0}, 32'h1);
        end
        give_verdict;
    end
endmodule
bind tmr_counter_top tmr_chk chk (.*);
